// file: common/fsr_pkg.sv
package fsr_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int WREG_TIME_NS = 2000;
  localparam int WREG_CYC = (WREG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [6:0] WREG_CNT_INIT = 7'(WREG_CYC - 1);

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] OPC_WREG = 8'h01;
  localparam logic [7:0] OPC_PP = 8'h02;
  localparam logic [7:0] OPC_WDIS = 8'h04;
  localparam logic [7:0] OPC_RDST1 = 8'h05;
  localparam logic [7:0] OPC_WENA = 8'h06;
  localparam logic [7:0] OPC_RDST2 = 8'h07;
  localparam logic [7:0] OPC_CLRST = 8'h30;
  localparam logic [7:0] OPC_BULK = 8'h60;
  localparam logic [7:0] OPC_ESUS = 8'h75;
  localparam logic [7:0] OPC_PSUS = 8'h85;
  localparam logic [7:0] OPC_SE = 8'hD8;
  localparam logic [7:0] OPC_SRST = 8'hF0;

  // ----------------------------------------
  // Status register one layout and resets
  // ----------------------------------------
  localparam int SWD_BIT = 7;
  localparam int PERR_BIT = 6;
  localparam int EERR_BIT = 5;
  localparam int BP_MSB = 4;
  localparam int BP_LSB = 2;
  localparam int WLATCH_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [2:0] BP_VOL_RST = 3'h7;
  localparam logic [2:0] BP_NV_RST = 3'h0;
  localparam logic SWD_NV_RST = 1'b0;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ----------------------------------------
  // Frame bit counts
  // ----------------------------------------
  localparam logic [4:0] CNT_CMD = 5'h08;
  localparam logic [4:0] CNT_DATA = 5'h10;

  typedef enum logic [2:0] {OP_IDLE, OP_WREG, OP_PROG, OP_ERASE, OP_BULK} fsr_op_t;

endpackage

// file: common/fsr_frame_if.sv
`timescale 1ns/1ps
interface fsr_frame_if;
  logic [7:0] cmd_byte;
  logic [7:0] data_byte;
  logic [4:0] bit_cnt;
  logic [7:0] status_snap;

  modport link (
    output cmd_byte,
    output data_byte,
    output bit_cnt,
    input status_snap
  );

  modport ctrl (
    input cmd_byte,
    input data_byte,
    input bit_cnt,
    output status_snap
  );
endinterface

// file: src/fsr_link_front.sv
`timescale 1ns/1ps
module fsr_link_front
  import fsr_pkg::*;
(
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Reset
  input wire logic reset_n,
  // Frame toward the controller
  fsr_frame_if.link frame
);

  logic in_frame;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [2:0] out_phase;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic [7:0] next_shift = {shift_in[6:0], si};
  wire logic at_top = (frame.bit_cnt == CNT_DATA);
  wire logic [4:0] next_bit_cnt = !in_frame ? 5'h01 :
                                  (at_top ? CNT_DATA : frame.bit_cnt + 5'h01);
  wire logic is_rd1 = (frame.cmd_byte == OPC_RDST1);
  wire logic is_rd = is_rd1 || (frame.cmd_byte == OPC_RDST2);
  wire logic past_cmd = (frame.bit_cnt >= CNT_CMD);
  wire logic load_out = in_frame && is_rd && past_cmd && (out_phase == 3'h0);
  // Second status register is reserved and reads zero
  wire logic [7:0] out_byte = is_rd1 ? frame.status_snap : 8'h00;

  // ----------------------------------------
  // Input side, rising edge
  // ----------------------------------------
  // Frame contents are not cleared by cs_n so the other domain reads them after the frame
  always_ff @(posedge sck or negedge reset_n or posedge cs_n) begin
    if (!reset_n) in_frame <= 1'b0;
    else if (cs_n) in_frame <= 1'b0;
    else in_frame <= 1'b1;
  end

  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      shift_in <= 8'h00;
      out_phase <= 3'h0;
      frame.bit_cnt <= 5'h00;
      frame.cmd_byte <= 8'h00;
      frame.data_byte <= 8'h00;
    end else begin
      shift_in <= next_shift;
      out_phase <= in_frame ? out_phase + 3'h1 : 3'h1;
      frame.bit_cnt <= next_bit_cnt;
      if (next_bit_cnt == CNT_CMD) frame.cmd_byte <= next_shift;
      if (next_bit_cnt == CNT_DATA && !at_top) frame.data_byte <= next_shift;
    end
  end

  // ----------------------------------------
  // Output side, falling edge
  // ----------------------------------------
  always_ff @(negedge sck or negedge reset_n or posedge cs_n) begin
    if (!reset_n) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      shift_out <= 8'h00;
    end else if (cs_n) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      shift_out <= 8'h00;
    end else if (load_out) begin
      so <= out_byte[7];
      so_oe <= 1'b1;
      shift_out <= {out_byte[6:0], 1'b0};
    end else begin
      so <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

endmodule

// file: src/fsr_status_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - Volatile bits return to defaults on power-on, hardware or software reset.
// - Nonvolatile bits keep their stored value across hardware and software resets.
// - Disable bit set with protect pin low refuses register writes.
// - Protect pin high or disable bit clear lets register writes change protection.
// - Program failure or protected program target sets the program error flag.
// - Error flags ignore register writes and clear only on clear status or reset.
// - Erase failure or protected sector erase sets the erase error flag.
// - Whole-array erase hitting a protected sector leaves erase error clear.
// - Nonzero protect field blocks program and erase of the selected area.
// - Whole-array erase runs only when all protect bits are zero.
// - Write enable latch set by enable, cleared by disable, not loaded from register write data.
// - Latch clear means register write, program and erase commands are ignored.
// - Latch clears when a program, register write or erase finishes cleanly.
// - Latch is zero after power-up, hardware reset and software reset.
// - Busy bit is one while any operation runs or an error flag is set, zero otherwise.
// - While busy only status reads, suspends, clear status and reset are taken.
// - Suspend commands only taken while the matching array operation runs.
// - A set error flag holds busy and refuses work until clear status.
// - Status read uses code 05h, register write uses code 01h.
// - Lock bit set holds the protect field unchanged until reset.
module fsr_status_ctrl
  import fsr_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic por_n,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Protect pin
  input wire logic wp_n,
  // Configuration bits
  input wire logic protect_volatility_sel,
  input wire logic freeze_lock,
  // Array engine
  input wire logic target_in_bp_range,
  input wire logic target_locked,
  input wire logic core_done,
  input wire logic core_fail,
  input wire logic core_prot_hit,
  output logic prog_start,
  output logic erase_start,
  output logic bulk_start,
  output logic suspend_prog,
  output logic suspend_erase,
  // Register view
  output logic [7:0] status_one
);

  // ----------------------------------------
  // Link front end
  // ----------------------------------------
  fsr_frame_if frame ();

  fsr_link_front u_front (
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .so(so),
    .so_oe(so_oe),
    .reset_n(reset_n),
    .frame(frame)
  );

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic wp_meta;
  logic wp_sync;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      wp_meta <= 1'b0;
      wp_sync <= 1'b0;
    end else begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      wp_meta <= wp_n;
      wp_sync <= wp_meta;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  fsr_op_t op_state;
  logic [6:0] wreg_cnt;
  logic [7:0] wreg_data;
  logic swd_nv;
  logic [2:0] bp_nv;
  logic [2:0] bp_vol;
  logic wlatch;
  logic p_err;
  logic e_err;
  logic soft_rst;

  function automatic logic fsr_busy_ok(input logic [7:0] op);
    return (op == OPC_RDST1) || (op == OPC_RDST2) || (op == OPC_ESUS) ||
           (op == OPC_PSUS) || (op == OPC_CLRST) || (op == OPC_SRST);
  endfunction

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Frame contents are stable once cs_n is seen high, the front end holds them
  wire logic frame_end = cs_sync && !cs_prev;
  wire logic [7:0] cmd = frame.cmd_byte;
  wire logic has_cmd = (frame.bit_cnt >= CNT_CMD);
  wire logic has_data = (frame.bit_cnt == CNT_DATA);
  wire logic go = frame_end && has_cmd;

  wire logic [2:0] bp_eff = protect_volatility_sel ? bp_vol : bp_nv;
  wire logic op_run = (op_state != OP_IDLE);
  wire logic busy = op_run || p_err || e_err;
  wire logic accept = go && (!busy || fsr_busy_ok(cmd));
  wire logic hw_locked = swd_nv && !wp_sync;
  wire logic armed = accept && wlatch && !busy;

  wire logic do_wena = accept && !busy && (cmd == OPC_WENA);
  wire logic do_wdis = accept && !busy && (cmd == OPC_WDIS);
  wire logic do_clrst = accept && (cmd == OPC_CLRST);
  wire logic do_srst = accept && (cmd == OPC_SRST);
  wire logic do_wreg = armed && (cmd == OPC_WREG) && has_data && !hw_locked;

  // Protect field applies only when nonzero; individual locks always apply
  wire logic blocked = ((bp_eff != 3'h0) && target_in_bp_range) || target_locked;
  wire logic req_prog = armed && (cmd == OPC_PP);
  wire logic req_erase = armed && (cmd == OPC_SE);
  wire logic do_prog = req_prog && !blocked;
  wire logic do_erase = req_erase && !blocked;
  wire logic prog_refused = req_prog && blocked;
  wire logic erase_refused = req_erase && blocked;
  wire logic do_bulk = armed && (cmd == OPC_BULK) && (bp_eff == 3'h0);

  wire logic do_susp_p = accept && (cmd == OPC_PSUS) && (op_state == OP_PROG);
  wire logic do_susp_e = accept && (cmd == OPC_ESUS) && (op_state == OP_ERASE);

  // ----------------------------------------
  // Completion
  // ----------------------------------------
  wire logic array_op = (op_state == OP_PROG) || (op_state == OP_ERASE) ||
                        (op_state == OP_BULK);
  wire logic fin = array_op && core_done;
  wire logic wreg_fin = (op_state == OP_WREG) && (wreg_cnt == 7'h00);
  wire logic fail_p = fin && core_fail && (op_state == OP_PROG);
  // A protected sector met by a whole-array erase is not an error
  wire logic fail_e = fin && core_fail && ((op_state == OP_ERASE) ||
                      ((op_state == OP_BULK) && !core_prot_hit));
  wire logic ok_fin = (fin && !core_fail) || wreg_fin;
  wire logic set_p = fail_p || prog_refused;
  wire logic set_e = fail_e || erase_refused;

  wire logic bp_write = wreg_fin && !freeze_lock;
  wire logic [2:0] wreg_bp = wreg_data[BP_MSB:BP_LSB];

  wire logic [7:0] next_status = {swd_nv, p_err, e_err, bp_eff, wlatch, busy};

  // ----------------------------------------
  // Operation sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) soft_rst <= 1'b0;
    else soft_rst <= do_srst;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_state <= OP_IDLE;
    end else if (soft_rst) begin
      op_state <= OP_IDLE;
    end else begin
      unique case (op_state)
        OP_IDLE: begin
          if (do_wreg) op_state <= OP_WREG;
          else if (do_prog) op_state <= OP_PROG;
          else if (do_erase) op_state <= OP_ERASE;
          else if (do_bulk) op_state <= OP_BULK;
        end
        OP_WREG: begin
          if (wreg_fin) op_state <= OP_IDLE;
        end
        OP_PROG, OP_ERASE, OP_BULK: begin
          if (core_done) op_state <= OP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wreg_cnt <= 7'h00;
      wreg_data <= 8'h00;
    end else if (do_wreg) begin
      wreg_cnt <= WREG_CNT_INIT;
      wreg_data <= frame.data_byte;
    end else if (wreg_cnt != 7'h00) begin
      wreg_cnt <= wreg_cnt - 7'h01;
    end
  end

  // ----------------------------------------
  // Write enable latch and error flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) wlatch <= 1'b0;
    else if (soft_rst) wlatch <= 1'b0;
    else if (do_wena) wlatch <= 1'b1;
    else if (do_wdis || ok_fin) wlatch <= 1'b0;
  end

  // A failure in the same cycle as clear status wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p_err <= 1'b0;
      e_err <= 1'b0;
    end else if (soft_rst) begin
      p_err <= 1'b0;
      e_err <= 1'b0;
    end else begin
      if (set_p) p_err <= 1'b1;
      else if (do_clrst) p_err <= 1'b0;
      if (set_e) e_err <= 1'b1;
      else if (do_clrst) e_err <= 1'b0;
    end
  end

  // ----------------------------------------
  // Protection bits
  // ----------------------------------------
  // Nonvolatile cells answer only to power-on, not to the device resets
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      swd_nv <= SWD_NV_RST;
      bp_nv <= BP_NV_RST;
    end else begin
      if (wreg_fin) swd_nv <= wreg_data[SWD_BIT];
      if (bp_write && !protect_volatility_sel) bp_nv <= wreg_bp;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) bp_vol <= BP_VOL_RST;
    else if (soft_rst) bp_vol <= BP_VOL_RST;
    else if (bp_write && protect_volatility_sel) bp_vol <= wreg_bp;
  end

  // ----------------------------------------
  // Outputs and status snapshot
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_one <= STATUS_RST;
      prog_start <= 1'b0;
      erase_start <= 1'b0;
      bulk_start <= 1'b0;
      suspend_prog <= 1'b0;
      suspend_erase <= 1'b0;
    end else begin
      status_one <= next_status;
      prog_start <= do_prog && !soft_rst;
      erase_start <= do_erase && !soft_rst;
      bulk_start <= do_bulk && !soft_rst;
      suspend_prog <= do_susp_p;
      suspend_erase <= do_susp_e;
    end
  end

  // Snapshot only changes between frames so the link side sees a steady byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) frame.status_snap <= STATUS_RST;
    else if (cs_sync) frame.status_snap <= status_one;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_enable_sets_latch: assert property (
    @(posedge clk) disable iff (!reset_n)
    do_wena && !soft_rst |-> ##2 status_one[WLATCH_BIT])
    else $error("write enable did not reach status");

  a_hw_lock_refuse: assert property (
    @(posedge clk) disable iff (!reset_n)
    (go && cmd == OPC_WREG && swd_nv && !wp_sync) |=> (op_state != OP_WREG))
    else $error("register write taken while locked");

  a_perr_sticky: assert property (
    @(posedge clk) disable iff (!reset_n)
    (p_err && !do_clrst && !soft_rst) |=> p_err)
    else $error("program error cleared without clear status");

  a_err_holds_busy: assert property (
    @(posedge clk) disable iff (!reset_n)
    (p_err || e_err) |=> status_one[BUSY_BIT])
    else $error("busy dropped while an error flag is set");

  a_bulk_needs_clear: assert property (
    @(posedge clk) disable iff (!reset_n)
    bulk_start |-> ($past(bp_eff) == 3'h0))
    else $error("whole-array erase started with protection set");

  a_done_clears_latch: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ok_fin && !do_wena) |-> ##2 !status_one[WLATCH_BIT])
    else $error("latch still set after clean completion");

  a_blocked_prog_err: assert property (
    @(posedge clk) disable iff (!reset_n)
    (prog_refused && !soft_rst) |=> (p_err && !prog_start) ##1 status_one[PERR_BIT])
    else $error("blocked program did not flag an error");

  a_busy_ignores_enable: assert property (
    @(posedge clk) disable iff (!reset_n)
    (busy && !wlatch && go && cmd == OPC_WENA) |=> !wlatch)
    else $error("write enable taken while busy");

  a_suspend_active: assert property (
    @(posedge clk) disable iff (!reset_n)
    suspend_prog |-> ($past(op_state) == OP_PROG))
    else $error("program suspend without a program running");

  a_bulk_prot_quiet: assert property (
    @(posedge clk) disable iff (!reset_n)
    (op_state == OP_BULK && core_done && core_prot_hit) |=> (e_err == $past(e_err)))
    else $error("whole-array erase flagged a protected sector");

  a_freeze_holds_bp: assert property (
    @(posedge clk) disable iff (!reset_n)
    (freeze_lock && !soft_rst && $stable(protect_volatility_sel)) |=> $stable(bp_eff))
    else $error("protect field changed under lock");

  a_wreg_duration: assert property (
    @(posedge clk) disable iff (!reset_n)
    (do_wreg && !soft_rst) |=> (op_state == OP_WREG)[*8])
    else $error("register write ended too early");

  a_latch_gates_prog: assert property (
    @(posedge clk) disable iff (!reset_n)
    prog_start |-> $past(wlatch))
    else $error("program started with latch clear");

  a_srst_clears: assert property (
    @(posedge clk) disable iff (!reset_n)
    soft_rst |=> (!wlatch && !p_err && !e_err && bp_vol == BP_VOL_RST))
    else $error("software reset left volatile bits set");

endmodule

// file: bench/fsr_host_model.sv
`timescale 1ns/1ps
module fsr_host_model (
  // Serial link toward the device
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic [7:0] rd_byte;
  event rd_done;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    rd_byte = 8'h00;
  end

  // ----------------------------------------
  // One frame, mode 0, clock stands still between frames
  // ----------------------------------------
  task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int nbits);
    logic [15:0] sh;
    sh = {op, dat};
    cs_n = 1'b0;
    #10;
    for (int i = 0; i < nbits; i++) begin
      si = sh[15 - i];
      #16 sck = 1'b1;
      // A released output shifts in unknowns so a missing enable cannot pass
      if (i >= 8) rd_byte = {rd_byte[6:0], so_oe ? so : 1'bx};
      #16 sck = 1'b0;
    end
    #10 cs_n = 1'b1;
    si = ~si;
    if (op == 8'h05) ->rd_done;
    #200;
  endtask
endmodule

// file: bench/fsr_status_ctrl_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module fsr_status_ctrl_tb_top;
  import fsr_pkg::*;
  logic clk, reset_n, por_n, sck, cs_n, si, so, so_oe, wp_n;
  logic protect_volatility_sel, freeze_lock, target_in_bp_range, target_locked;
  logic core_done, core_fail, core_prot_hit;
  logic prog_start, erase_start, bulk_start, suspend_prog, suspend_erase;
  logic [7:0] status_one, e, r;
  logic [7:0] exp_q[$];
  int err_count, check_count, n_prog, n_erase, n_bulk, n_sp, n_se;

  fsr_status_ctrl uut (.clk(clk), .reset_n(reset_n), .por_n(por_n), .sck(sck),
    .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n),
    .protect_volatility_sel(protect_volatility_sel), .freeze_lock(freeze_lock),
    .target_in_bp_range(target_in_bp_range), .target_locked(target_locked),
    .core_done(core_done), .core_fail(core_fail), .core_prot_hit(core_prot_hit),
    .prog_start(prog_start), .erase_start(erase_start), .bulk_start(bulk_start),
    .suspend_prog(suspend_prog), .suspend_erase(suspend_erase), .status_one(status_one));

  fsr_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    n_prog += int'(prog_start === 1'b1);
    n_erase += int'(erase_start === 1'b1);
    n_bulk += int'(bulk_start === 1'b1);
    n_sp += int'(suspend_prog === 1'b1);
    n_se += int'(suspend_erase === 1'b1);
  end

  // ----------------------------------------
  // Read-back monitor
  // ----------------------------------------
  always @(host.rd_done) begin
    if (exp_q.size() == 0) begin
      err_count++;
      $display("MISMATCH t=%0t unexpected read", $time);
    end else begin
      e = exp_q.pop_front();
      `CHK(host.rd_byte, e)
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task cmd(input logic [7:0] op);
    host.xfer(op, 8'h00, 8);
  endtask
  // Waits out the whole write time so the commit is visible
  task wreg(input logic [7:0] d);
    host.xfer(OPC_WREG, d, 16);
    cyc(WREG_CYC + 20);
  endtask
  task rd(input logic [7:0] x);
    exp_q.push_back(x);
    host.xfer(OPC_RDST1, 8'h00, 16);
  endtask
  task core(input logic f, input logic p);
    cyc(5);
    core_done = 1'b1;
    core_fail = f;
    core_prot_hit = p;
    cyc(1);
    core_done = 1'b0;
    core_fail = 1'b0;
    core_prot_hit = 1'b0;
    cyc(2);
  endtask
  task do_reset(input logic por);
    cyc(1);
    reset_n = 1'b0;
    if (por) por_n = 1'b0;
    cyc(5);
    reset_n = 1'b1;
    por_n = 1'b1;
    cyc(4);
  endtask
  task tend(input string s);
    $display("test %s done", s);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    $display("MISMATCH t=%0t timeout", $time);
    conclude;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    por_n = 1'b0;
    wp_n = 1'b1;
    protect_volatility_sel = 1'b1;
    freeze_lock = 1'b0;
    target_in_bp_range = 1'b0;
    target_locked = 1'b0;
    core_done = 1'b0;
    core_fail = 1'b0;
    core_prot_hit = 1'b0;
    r = 8'($urandom(32'hB6A20870));
    do_reset(1'b1);
    rd(8'h1C);
    wreg(8'h80);
    rd(8'h1C);
    cmd(OPC_WENA);
    rd(8'h1E);
    tend("reset_enable");
    r = 8'($urandom);
    host.xfer(OPC_WREG, {1'h1, r[1:0], 3'h2, r[3:2]}, 16);
    rd(8'h1F);
    cyc(WREG_CYC + 20);
    rd(8'h88);
    wp_n = 1'b0;
    cmd(OPC_WENA);
    rd(8'h8A);
    wreg(8'h00);
    rd(8'h8A);
    cmd(OPC_WDIS);
    rd(8'h88);
    cyc(1);
    wp_n = 1'b1;
    cmd(OPC_WENA);
    wreg(8'h00);
    rd(8'h00);
    cyc(1);
    freeze_lock = 1'b1;
    cmd(OPC_WENA);
    wreg(8'h1C);
    rd(8'h00);
    cyc(1);
    freeze_lock = 1'b0;
    tend("protect");
    target_locked = 1'b1;
    cmd(OPC_WENA);
    cmd(OPC_PP);
    rd(8'h43);
    wreg(8'h80);
    rd(8'h43);
    cmd(OPC_CLRST);
    rd(8'h02);
    cmd(OPC_WDIS);
    rd(8'h00);
    `CHK(n_prog, 0)
    cyc(1);
    target_locked = 1'b0;
    tend("program_error");
    cmd(OPC_WENA);
    wreg(8'h04);
    cmd(OPC_WENA);
    cmd(OPC_BULK);
    rd(8'h06);
    `CHK(n_bulk, 0)
    cyc(1);
    target_in_bp_range = 1'b1;
    cmd(OPC_SE);
    rd(8'h27);
    cmd(OPC_CLRST);
    `CHK(n_erase, 0)
    cyc(1);
    target_in_bp_range = 1'b0;
    wreg(8'h00);
    cmd(OPC_WENA);
    cmd(OPC_BULK);
    `CHK(n_bulk, 1)
    rd(8'h03);
    core(1'b1, 1'b1);
    cmd(OPC_WDIS);
    rd(8'h00);
    tend("whole_erase");
    cmd(OPC_WENA);
    cmd(OPC_SE);
    cmd(OPC_ESUS);
    cmd(OPC_PSUS);
    `CHK(n_erase, 1)
    `CHK(n_se, 1)
    `CHK(n_sp, 0)
    rd(8'h03);
    core(1'b0, 1'b0);
    rd(8'h00);
    cmd(OPC_WENA);
    cmd(OPC_SE);
    core(1'b1, 1'b0);
    rd(8'h23);
    cmd(OPC_SRST);
    rd(8'h1C);
    tend("sector_erase");
    cyc(1);
    protect_volatility_sel = 1'b0;
    rd(8'h00);
    r = 8'($urandom);
    cmd(OPC_WENA);
    wreg({1'h0, r[5:4], 3'h2, r[7:6]});
    rd(8'h08);
    do_reset(1'b0);
    rd(8'h08);
    cyc(1);
    protect_volatility_sel = 1'b1;
    rd(8'h1C);
    `CHK(status_one, 8'h1C)
    tend("volatility");
    conclude;
  end
endmodule
